// ---- rtl/pcb_defs.svh ----
/*
  Constants of the preset counter block: register offsets, field
  positions, reset values and timing figures.
  Assumes it is included by bare name from rtl/ files.
*/
`ifndef PCB_DEFS_SVH
`define PCB_DEFS_SVH

// Register byte offsets
`define PCB_OFS_CTRL   8'h00
`define PCB_OFS_SET1   8'h04
`define PCB_OFS_SECOND_STAGE_PRESET   8'h08
`define PCB_OFS_FUNC   8'h0c
`define PCB_OFS_COMP   8'h10
`define PCB_OFS_BSET   8'h14
`define PCB_OFS_PV     8'h18
`define PCB_OFS_BPV    8'h1c
`define PCB_OFS_STAT   8'h20

// Field positions
`define PCB_CTRL_RUN   0
`define PCB_CTRL_RKEY  1
`define PCB_FUNC_OS1   16
`define PCB_FUNC_OS2   17

// Reset values
`define PCB_FUNC_RST   32'h0000_0064
`define PCB_SET_RST    24'h00_0000
`define PCB_BSET_RST   14'h0000

// Count limits
`define PCB_PV_MAX     24'h0f_423f
`define PCB_PV_MIN_PM  24'hfe_7961
`define PCB_PV_ALLF    24'hff_ffff
`define PCB_BPV_MAX    14'h270f

// Timing
`define PCB_CLK_NS     40
`define PCB_MS_NS      1000000
`define PCB_OS_MIN_MS  10'd10
`define PCB_OS_MAX_MS  10'd1000
`define PCB_BGAP_MS    1
`define PCB_CYC_PER_MS (`PCB_MS_NS / `PCB_CLK_NS)

`endif

// ---- rtl/pcb_pkg.sv ----
/*
  Types of the preset counter block.
  Assumes pcb_defs.svh supplies the numeric constants.
*/
package pcb_pkg;

  // Power-up strap options
  typedef struct packed {
    logic two_stage;
    logic pm_range;
  } pcb_cfg_t;

  // Function settings, applied on entry to run mode
  typedef struct packed {
    logic       os2;
    logic       os1;
    logic [9:0] os_ms;
  } pcb_func_t;

  // Register write sequencing
  typedef enum logic [2:0] {
    PCB_WR_IDLE = 3'b001,
    PCB_WR_DO   = 3'b010,
    PCB_WR_RESP = 3'b100
  } pcb_wr_t;

endpackage : pcb_pkg

// ---- rtl/pcb_sync_edge.sv ----
/*
  Two-flop synchroniser with rising edge detect, one lane per input.
  Assumes one clock; the first stage feeds only the second.
*/
`timescale 1ns/1ps
`default_nettype none
module pcb_sync_edge #(
  parameter int N = 5
) (
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  input  wire logic [N-1:0] sig_i,
  output logic      [N-1:0] lvl_o,
  output logic      [N-1:0] rise_o
);
  logic [N-1:0] s1_q, s2_q, s3_q;

  // Per-lane synchroniser and edge history
  genvar g;
  for (g = 0; g < N; g++) begin : g_lane
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        s1_q[g] <= 1'b0;
        s2_q[g] <= 1'b0;
        s3_q[g] <= 1'b0;
      end else begin
        s1_q[g] <= sig_i[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
      end
    end
    assign lvl_o[g]  = s2_q[g];
    assign rise_o[g] = s2_q[g] & ~s3_q[g];
  end
endmodule : pcb_sync_edge
`default_nettype wire

// ---- rtl/pcb_oneshot.sv ----
/*
  Millisecond one-shot: restarts on fire, drops at once on clear.
  Assumes the caller clamps dur_ms_i to the legal span.
*/
`timescale 1ns/1ps
`default_nettype none
module pcb_oneshot #(
  parameter int CYC_PER_MS = 25000
) (
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       fire_i,
  input  wire logic       clr_i,
  input  wire logic [9:0] dur_ms_i,
  output logic            active_o
);
  logic [15:0] pre_q, pre_d;
  logic [9:0]  ms_q, ms_d;
  logic        act_q, act_d;

  // Clear beats fire, so a reset always wins
  always_comb begin
    pre_d = pre_q;
    ms_d  = ms_q;
    act_d = act_q;
    if (clr_i) begin
      act_d = 1'b0;
    end else if (fire_i) begin
      act_d = 1'b1;
      pre_d = 16'h0000;
      ms_d  = dur_ms_i;
    end else if (act_q) begin
      if (pre_q == 16'(CYC_PER_MS - 1)) begin
        pre_d = 16'h0000;
        ms_d  = ms_q - 10'h001;
        if (ms_q == 10'h001) begin
          act_d = 1'b0;
        end
      end else begin
        pre_d = pre_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_q <= 16'h0000;
      ms_q  <= 10'h000;
      act_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      ms_q  <= ms_d;
      act_q <= act_d;
    end
  end

  assign active_o = act_q;
endmodule : pcb_oneshot
`default_nettype wire

// ---- rtl/pcb_top.sv ----
/*
  Preset counter with batch counter, AXI4-Lite register access.
  Assumes one 25 MHz clock, inputs synchronous, straps and the kept
  batch output level stable at power-up.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcb_defs.svh"
module pcb_top
  import pcb_pkg::*;
#(
  parameter int CYC_PER_MS = `PCB_CYC_PER_MS,
  parameter int BGAP_CYC   = `PCB_BGAP_MS * `PCB_CYC_PER_MS
) (
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        count_input_a_i,
  input  wire logic        count_input_b_i,
  input  wire logic        reset_in_i,
  input  wire logic        batch_reset_i,
  input  wire logic        comp_in_i,
  input  wire logic        strap_two_stage_i,
  input  wire logic        strap_pm_range_i,
  input  wire logic        kept_batch_out_i,
  output logic             out1_o,
  output logic             out2_o,
  output logic             batch_out_o,
  output logic             error_o,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  logic [4:0] lvl, rise;
  logic       up_ev, dn_ev, rst_lvl, brst_lvl, comp_ev;

  // Field inputs cleaned up before use
  pcb_sync_edge #(.N(5)) u_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .sig_i     ({comp_in_i, batch_reset_i, reset_in_i,
                 count_input_b_i, count_input_a_i}),
    .lvl_o     (lvl),
    .rise_o    (rise)
  );
  assign up_ev    = rise[0];
  assign dn_ev    = rise[1];
  assign rst_lvl  = lvl[2];
  assign brst_lvl = lvl[3];
  assign comp_ev  = rise[4];

  // Register bus state
  pcb_wr_t     wst_q, wst_d;
  logic        awr_q, awr_d, wr_q, wr_d, bv_q, bv_d;
  logic        awok_q, awok_d, wok_q, wok_d;
  logic [7:0]  wa_q, wa_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0]  ws_q, ws_d;
  logic        arr_q, arr_d, rv_q, rv_d;
  logic [31:0] rd_q, rd_d;
  logic [1:0]  rr_q, rr_d, br_q, br_d;
  logic        wdo;

  // Software-visible settings
  logic        run_q, run_d, rkey_q, rkey_d;
  logic [23:0] set1_q, set1_d, second_stage_preset_q, second_stage_preset_d;
  logic [23:0] comp_q, comp_d, comp_act_q, comp_act_d;
  pcb_func_t   fsh_q, fsh_d, fact_q, fact_d;
  logic [13:0] bset_q, bset_d;

  // Write channel: address and data taken in any order
  always_comb begin
    wst_d  = wst_q;
    awr_d  = awr_q;
    wr_d   = wr_q;
    awok_d = awok_q;
    wok_d  = wok_q;
    wa_d   = wa_q;
    wd_d   = wd_q;
    ws_d   = ws_q;
    bv_d   = bv_q;
    br_d   = br_q;
    wdo    = 1'b0;
    if (s_axi_awvalid && awr_q) begin
      awr_d  = 1'b0;
      awok_d = 1'b1;
      wa_d   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_q) begin
      wr_d  = 1'b0;
      wok_d = 1'b1;
      wd_d  = s_axi_wdata;
      // Strobes kept with the data; the master may move them after
      ws_d  = s_axi_wstrb;
    end
    unique case (wst_q)
      PCB_WR_IDLE: begin
        if (awok_q && wok_q) begin
          wst_d = PCB_WR_DO;
        end
      end
      PCB_WR_DO: begin
        wdo    = 1'b1;
        awok_d = 1'b0;
        wok_d  = 1'b0;
        bv_d   = 1'b1;
        br_d   = (wa_q[1:0] == 2'b00 && wa_q <= `PCB_OFS_BSET)
                 ? 2'b00 : 2'b10;
        wst_d  = PCB_WR_RESP;
      end
      PCB_WR_RESP: begin
        if (s_axi_bready) begin
          bv_d  = 1'b0;
          awr_d = 1'b1;
          wr_d  = 1'b1;
          wst_d = PCB_WR_IDLE;
        end
      end
      default: wst_d = PCB_WR_IDLE;
    endcase
  end

  // Settings writes; function fields go to a shadow copy first
  always_comb begin
    run_d      = run_q;
    rkey_d     = 1'b0;
    set1_d     = set1_q;
    second_stage_preset_d     = second_stage_preset_q;
    comp_d     = comp_q;
    fsh_d      = fsh_q;
    bset_d     = bset_q;
    fact_d     = fact_q;
    comp_act_d = comp_act_q;
    if (wdo && wa_q == `PCB_OFS_CTRL && ws_q[0]) begin
      run_d  = wd_q[`PCB_CTRL_RUN];
      rkey_d = wd_q[`PCB_CTRL_RKEY];
    end
    if (wdo && wa_q == `PCB_OFS_SET1 && &ws_q[2:0]) begin
      set1_d = wd_q[23:0];
    end
    if (wdo && wa_q == `PCB_OFS_SECOND_STAGE_PRESET && &ws_q[2:0]) begin
      second_stage_preset_d = wd_q[23:0];
    end
    if (wdo && wa_q == `PCB_OFS_COMP && &ws_q[2:0]) begin
      comp_d = wd_q[23:0];
    end
    if (wdo && wa_q == `PCB_OFS_FUNC && &ws_q[2:0]) begin
      fsh_d.os1 = wd_q[`PCB_FUNC_OS1];
      fsh_d.os2 = wd_q[`PCB_FUNC_OS2];
      // Lengths with bits 9:0 under the minimum go to it; others out of span go to the maximum
      if (wd_q[9:0] < `PCB_OS_MIN_MS) begin
        fsh_d.os_ms = `PCB_OS_MIN_MS;
      end else if (wd_q[15:10] != 6'h00 ||
                   wd_q[9:0] > `PCB_OS_MAX_MS) begin
        fsh_d.os_ms = `PCB_OS_MAX_MS;
      end else begin
        fsh_d.os_ms = wd_q[9:0];
      end
    end
    if (wdo && wa_q == `PCB_OFS_BSET && &ws_q[1:0]) begin
      bset_d = (wd_q[13:0] > `PCB_BPV_MAX) ? `PCB_BPV_MAX : wd_q[13:0];
    end
    // Function and compensation settings take hold only as run mode is entered
    if (run_d && !run_q) begin
      fact_d     = fsh_q;
      comp_act_d = comp_q;
    end
  end

  // Counting state
  pcb_cfg_t    cfg_q, cfg_d;
  logic        boot_q, boot_d;
  logic [23:0] pv_q, pv_d;
  logic        ovf_q, ovf_d, unf_q, unf_d, err, err_q;
  logic        upd_q, upd_d;
  logic        eq1_q, eq1_d, eq2_q, eq2_d;
  logic        hld1_q, hld1_d, hld2_q, hld2_d;
  logic        trig1, trig2, rst_any;
  logic [23:0] pv_min;
  logic        os1_act, os2_act;

  assign err     = ovf_q | unf_q;
  assign rst_any = rst_lvl | rkey_q;
  assign pv_min  = cfg_q.pm_range ? `PCB_PV_MIN_PM : 24'h00_0000;

  // Present value, direction, range errors and preset matches
  always_comb begin
    cfg_d  = cfg_q;
    boot_d = 1'b0;
    pv_d   = pv_q;
    ovf_d  = ovf_q;
    unf_d  = unf_q;
    upd_d  = upd_q;
    if (boot_q) begin
      cfg_d.two_stage = strap_two_stage_i;
      cfg_d.pm_range  = strap_pm_range_i;
    end
    if (rst_any) begin
      pv_d  = 24'h00_0000;
      ovf_d = 1'b0;
      unf_d = 1'b0;
    end else if (comp_ev && cfg_q.pm_range && upd_q) begin
      pv_d = comp_act_q;
    end else if (!err && up_ev && !dn_ev) begin
      upd_d = 1'b1;
      if (pv_q == `PCB_PV_MAX) begin
        ovf_d = 1'b1;
        pv_d  = 24'h00_0000;
      end else begin
        pv_d = pv_q + 24'h00_0001;
      end
    end else if (!err && dn_ev && !up_ev) begin
      upd_d = 1'b0;
      if (pv_q == pv_min) begin
        unf_d = 1'b1;
        pv_d  = 24'h00_0000;
      end else begin
        pv_d = pv_q - 24'h00_0001;
      end
    end
    // Matches follow set edits too, so an edit equal to the present value fires
    eq1_d = cfg_q.two_stage && (pv_q == set1_q);
    eq2_d = (pv_q == second_stage_preset_q);
    // Plus/minus parts re-arm during reset; others keep comparing the present value
    if (rst_any && cfg_q.pm_range) begin
      eq1_d = 1'b0;
      eq2_d = 1'b0;
    end
  end

  // A fresh match fires; repeated reaches fire again
  assign trig2 = eq2_d && !eq2_q && !rst_any && !err;
  assign trig1 = cfg_q.two_stage
                 ? (eq1_d && !eq1_q && !rst_any && !err) : trig2;

  // Held outputs drop only on reset, never on an error
  always_comb begin
    hld1_d = hld1_q;
    hld2_d = hld2_q;
    if (rst_any) begin
      hld1_d = 1'b0;
      hld2_d = 1'b0;
    end else begin
      hld1_d = hld1_q | trig1;
      hld2_d = hld2_q | trig2;
    end
  end

  // One-shots: reset clears, compensation has no say
  pcb_oneshot #(.CYC_PER_MS(CYC_PER_MS)) u_os1 (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .fire_i    (trig1),
    .clr_i     (rst_any),
    .dur_ms_i  (fact_q.os_ms),
    .active_o  (os1_act)
  );
  pcb_oneshot #(.CYC_PER_MS(CYC_PER_MS)) u_os2 (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .fire_i    (trig2),
    .clr_i     (rst_any),
    .dur_ms_i  (fact_q.os_ms),
    .active_o  (os2_act)
  );

  // Batch counter state
  logic [13:0] bpv_q, bpv_d;
  logic        bout_q, bout_d;
  logic [15:0] bgap_q, bgap_d;
  logic        out1_q, out1_d, out2_q, out2_d;

  // Batch value, spacing guard and sticky batch output
  always_comb begin
    bpv_d  = bpv_q;
    bout_d = bout_q;
    bgap_d = (bgap_q != 16'h0000) ? bgap_q - 16'h0001 : bgap_q;
    if (boot_q) begin
      bout_d = kept_batch_out_i;
    end
    // Reaches closer than the guard are dropped, not queued
    if (trig2 && bgap_q == 16'h0000) begin
      bgap_d = 16'(BGAP_CYC - 1);
      bpv_d  = (bpv_q == `PCB_BPV_MAX) ? 14'h0000
               : bpv_q + 14'h0001;
    end
    // Only the batch reset touches the batch side
    if (brst_lvl) begin
      bpv_d  = 14'h0000;
      bout_d = 1'b0;
    end else if (bset_q != 14'h0000 && bpv_q >= bset_q) begin
      bout_d = 1'b1;
    end
  end

  // Output selection, registered so the pins come from flops
  always_comb begin
    out1_d = fact_q.os1 ? os1_act : hld1_q;
    out2_d = fact_q.os2 ? os2_act : hld2_q;
  end

  // Read data mux
  always_comb begin
    arr_d = arr_q;
    rv_d  = rv_q;
    rd_d  = rd_q;
    rr_d  = rr_q;
    if (s_axi_arvalid && arr_q) begin
      arr_d = 1'b0;
      rv_d  = 1'b1;
      rr_d  = 2'b00;
      unique case (s_axi_araddr)
        `PCB_OFS_CTRL: rd_d = {31'h0000_0000, run_q};
        `PCB_OFS_SET1: rd_d = {8'h00, set1_q};
        `PCB_OFS_SECOND_STAGE_PRESET: rd_d = {8'h00, second_stage_preset_q};
        `PCB_OFS_FUNC: rd_d = {14'h0000, fsh_q.os2, fsh_q.os1,
                               6'h00, fsh_q.os_ms};
        `PCB_OFS_COMP: rd_d = {8'h00, comp_q};
        `PCB_OFS_BSET: rd_d = {18'h0_0000, bset_q};
        `PCB_OFS_PV:   rd_d = {8'h00, ovf_q ? `PCB_PV_ALLF : pv_q};
        `PCB_OFS_BPV:  rd_d = {18'h0_0000, bpv_q};
        `PCB_OFS_STAT: rd_d = {23'h00_0000, cfg_q.pm_range,
                               cfg_q.two_stage, rst_any, upd_q,
                               unf_q, ovf_q, bout_q, out2_q, out1_q};
        default: begin
          rd_d = 32'h0000_0000;
          rr_d = 2'b10;
        end
      endcase
    end else if (rv_q && s_axi_rready) begin
      rv_d  = 1'b0;
      arr_d = 1'b1;
    end
  end

  // Register bank
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wst_q      <= PCB_WR_IDLE;
      awr_q      <= 1'b1;
      wr_q       <= 1'b1;
      awok_q     <= 1'b0;
      wok_q      <= 1'b0;
      wa_q       <= 8'h00;
      wd_q       <= 32'h0000_0000;
      ws_q       <= 4'h0;
      bv_q       <= 1'b0;
      br_q       <= 2'b00;
      arr_q      <= 1'b1;
      rv_q       <= 1'b0;
      rd_q       <= 32'h0000_0000;
      rr_q       <= 2'b00;
      run_q      <= 1'b1;
      rkey_q     <= 1'b0;
      set1_q     <= `PCB_SET_RST;
      second_stage_preset_q     <= `PCB_SET_RST;
      comp_q     <= `PCB_SET_RST;
      comp_act_q <= `PCB_SET_RST;
      fsh_q      <= pcb_func_t'(12'(`PCB_FUNC_RST));
      fact_q     <= pcb_func_t'(12'(`PCB_FUNC_RST));
      bset_q     <= `PCB_BSET_RST;
      cfg_q      <= '0;
      boot_q     <= 1'b1;
      pv_q       <= 24'h00_0000;
      ovf_q      <= 1'b0;
      unf_q      <= 1'b0;
      err_q      <= 1'b0;
      upd_q      <= 1'b1;
      eq1_q      <= 1'b1;
      eq2_q      <= 1'b1;
      hld1_q     <= 1'b0;
      hld2_q     <= 1'b0;
      bpv_q      <= 14'h0000;
      bout_q     <= 1'b0;
      bgap_q     <= 16'h0000;
      out1_q     <= 1'b0;
      out2_q     <= 1'b0;
    end else begin
      wst_q      <= wst_d;
      awr_q      <= awr_d;
      wr_q       <= wr_d;
      awok_q     <= awok_d;
      wok_q      <= wok_d;
      wa_q       <= wa_d;
      wd_q       <= wd_d;
      ws_q       <= ws_d;
      bv_q       <= bv_d;
      br_q       <= br_d;
      arr_q      <= arr_d;
      rv_q       <= rv_d;
      rd_q       <= rd_d;
      rr_q       <= rr_d;
      run_q      <= run_d;
      rkey_q     <= rkey_d;
      set1_q     <= set1_d;
      second_stage_preset_q     <= second_stage_preset_d;
      comp_q     <= comp_d;
      comp_act_q <= comp_act_d;
      fsh_q      <= fsh_d;
      fact_q     <= fact_d;
      bset_q     <= bset_d;
      cfg_q      <= cfg_d;
      boot_q     <= boot_d;
      pv_q       <= pv_d;
      ovf_q      <= ovf_d;
      unf_q      <= unf_d;
      err_q      <= ovf_d | unf_d;
      upd_q      <= upd_d;
      eq1_q      <= eq1_d;
      eq2_q      <= eq2_d;
      hld1_q     <= hld1_d;
      hld2_q     <= hld2_d;
      bpv_q      <= bpv_d;
      bout_q     <= bout_d;
      bgap_q     <= bgap_d;
      out1_q     <= out1_d;
      out2_q     <= out2_d;
    end
  end

  // Pins straight from flops
  assign out1_o        = out1_q;
  assign out2_o        = out2_q;
  assign batch_out_o   = bout_q;
  assign error_o       = err_q;
  assign s_axi_awready = awr_q;
  assign s_axi_wready  = wr_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
endmodule : pcb_top
`default_nettype wire

// ---- sim/pcb_sensor.sv ----
/*
  Sensor and contact model driving count, reset and compensation lines.
  Assumes the counter's clock; lines change just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pcb_sensor #(
  parameter int W = 4
) (
  input  wire logic       sys_clk_i,
  output logic      [4:0] sig_o
);
  // Open contacts until the bench asks for something
  initial sig_o = 5'h00;

  // Count pulses: equal width on both count lines, gap equal to width
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      sig_o[ch] <= 1'b1;
      repeat (W) @(posedge sys_clk_i);
      sig_o[ch] <= 1'b0;
      repeat (W) @(posedge sys_clk_i);
    end
  endtask : pulse

  // Level contact; one edge passes so no line is set twice at once
  task automatic put(input int ch, input logic l);
    sig_o[ch] <= l;
    @(posedge sys_clk_i);
  endtask : put
endmodule : pcb_sensor
`default_nettype wire

// ---- sim/pcb_top_props.sv ----
/*
  Checker of the counter pins: reset, batch and one-shot relations.
  Assumes bind into pcb_top and input levels held 8 cycles or more.
*/
`timescale 1ns/1ps
`default_nettype none
module pcb_top_props #(
  parameter int CYC_PER_MS = 25000
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic reset_in_i,
  input wire logic batch_reset_i,
  input wire logic kept_batch_out_i,
  input wire logic out1_o,
  input wire logic out2_o,
  input wire logic batch_out_o,
  input wire logic error_o
);
  localparam int OS_MIN = 9 * CYC_PER_MS;
  logic [15:0] hi_q, hi_d;
  logic [3:0]  rs_q, rs_d;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  // Run length of out2 (wrapping) and age of the last reset level (saturating)
  always_comb begin
    hi_d = out2_o ? hi_q + 16'h1 : 16'h0;
    rs_d = reset_in_i ? 4'h0 : rs_q + {3'h0, rs_q != 4'hf};
  end

  // Registers of the helper counters
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_q <= 16'h0;
      rs_q <= 4'hf;
    end else begin
      hi_q <= hi_d;
      rs_q <= rs_d;
    end
  end

  property p_rst_out;
    reset_in_i [*6] |-> !out1_o && !out2_o;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("out on in reset");
  property p_rst_err;
    reset_in_i [*6] |-> !error_o;
  endproperty
  a_rst_err: assert property (p_rst_err) else $error("error kept");
  property p_rst_bat;
    reset_in_i [*8] ##1 (reset_in_i && !batch_reset_i) |-> $stable(batch_out_o);
  endproperty
  a_rst_bat: assert property (p_rst_bat) else $error("batch moved");
  property p_bat_stick;
    (!batch_reset_i) [*8] ##0 batch_out_o |=> batch_out_o;
  endproperty
  a_bat_stick: assert property (p_bat_stick) else $error("batch fell");
  property p_bat_clr;
    batch_reset_i [*8] |-> !batch_out_o;
  endproperty
  a_bat_clr: assert property (p_bat_clr) else $error("batch on");
  property p_os_len;
    $fell(out2_o) |-> hi_q >= OS_MIN || rs_q < 4'h8;
  endproperty
  a_os_len: assert property (p_os_len) else $error("pulse short");
  property p_kept;
    $rose(nrst_i) |-> ##3 batch_out_o == kept_batch_out_i;
  endproperty
  a_kept: assert property (p_kept) else $error("batch not kept");
  property p_err_out;
    $rose(error_o) |-> $stable(out1_o) && $stable(out2_o);
  endproperty
  a_err_out: assert property (p_err_out) else $error("out moved");

  c_batch: cover property ($rose(batch_out_o));
  c_pulse: cover property ($fell(out2_o) && rs_q == 4'hf);
  c_err: cover property ($rose(error_o));
endmodule : pcb_top_props

bind pcb_top pcb_top_props #(.CYC_PER_MS(CYC_PER_MS)) u_props (
  .sys_clk_i, .nrst_i, .reset_in_i, .batch_reset_i, .kept_batch_out_i,
  .out1_o, .out2_o, .batch_out_o, .error_o);
`default_nettype wire

// ---- sim/pcb_top_tb.sv ----
/*
  Bench of the preset counter: bus master, sensor model, scenarios.
  Assumes the bus timing and register map of the counter's notes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcb_defs.svh"
module pcb_top_tb;
  localparam int CPM = 20;
  logic sys_clk_i, nrst_i, strap_two_stage_i, strap_pm_range_i;
  logic kept_batch_out_i, out1_o, out2_o, batch_out_o, error_o;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, r;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [4:0]  sig;
  int          n_mismatch, compares;

  pcb_sensor #(.W(4)) sen (.sys_clk_i, .sig_o(sig));
  pcb_top #(.CYC_PER_MS(CPM), .BGAP_CYC(10)) dut (
    .sys_clk_i, .nrst_i, .count_input_a_i(sig[0]), .count_input_b_i(sig[1]),
    .reset_in_i(sig[2]), .batch_reset_i(sig[3]), .comp_in_i(sig[4]),
    .strap_two_stage_i, .strap_pm_range_i, .kept_batch_out_i, .out1_o,
    .out2_o, .batch_out_o, .error_o, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // 25 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // Counts, verdict and the end of the run
  task automatic summarize;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : idle

  // Bus access; ready is looked at mid-cycle, where it already holds
  // what the next rising edge samples, so no race with the slave
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    logic ah, wh, dh;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (int k = 0; k < 100; k++) begin
      @(negedge sys_clk_i);
      ah = w ? s_axi_awready : s_axi_arready;
      wh = s_axi_wready;
      dh = w ? s_axi_bvalid : s_axi_rvalid;
      r = 32'(w ? s_axi_bresp : s_axi_rresp);
      v = s_axi_rdata;
      @(posedge sys_clk_i);
      if (ah) s_axi_awvalid <= 1'b0;
      if (ah) s_axi_arvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (dh) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        @(posedge sys_clk_i);
        return;
      end
    end
    n_mismatch++;
    summarize();
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(v, e);
  endtask : rdc

  // Main reset input held long enough for the pipeline to settle
  task automatic mrst;
    sen.put(2, 1'b1);
    idle(10);
    sen.put(2, 1'b0);
    idle(10);
  endtask : mrst

  task automatic pwr(input logic k, input logic s);
    kept_batch_out_i <= k;
    strap_two_stage_i <= s;
    nrst_i <= 1'b0;
    idle(2);
    nrst_i <= 1'b1;
    idle(8);
  endtask : pwr

  // Last-stage reach, counts under reset, edited set value
  task automatic s_count;
    bus(1'b1, `PCB_OFS_SECOND_STAGE_PRESET, 32'h3);
    chk(r, 32'h0);
    sen.pulse(0, 3);
    idle(8);
    chk(32'(out2_o), 32'h1);
    rdc(`PCB_OFS_BPV, 32'h1);
    sen.put(2, 1'b1);
    sen.pulse(0, 2);
    chk(32'(out2_o), 32'h0);
    rdc(`PCB_OFS_PV, 32'h0);
    sen.put(2, 1'b0);
    idle(8);
    rdc(`PCB_OFS_BPV, 32'h1);
    sen.pulse(0, 2);
    bus(1'b1, `PCB_OFS_SECOND_STAGE_PRESET, 32'h2);
    idle(8);
    chk(32'(out2_o), 32'h1);
    mrst();
  endtask : s_count

  // Batch: reset hold, zero set value, set lowered then raised
  task automatic s_batch;
    sen.put(3, 1'b1);
    idle(8);
    rdc(`PCB_OFS_BPV, 32'h0);
    sen.put(3, 1'b0);
    bus(1'b1, `PCB_OFS_SECOND_STAGE_PRESET, 32'h1);
    repeat (3) begin
      sen.pulse(0, 1);
      mrst();
    end
    rdc(`PCB_OFS_BPV, 32'h3);
    chk(32'(batch_out_o), 32'h0);
    bus(1'b1, `PCB_OFS_BSET, 32'h5);
    bus(1'b1, `PCB_OFS_BSET, 32'h2);
    idle(8);
    chk(32'(batch_out_o), 32'h1);
    bus(1'b1, `PCB_OFS_BSET, 32'h270f);
    idle(8);
    chk(32'(batch_out_o), 32'h1);
    sen.put(3, 1'b1);
    idle(10);
    sen.put(3, 1'b0);
  endtask : s_batch

  // One-shot below the minimum length, restarted by a second reach
  task automatic s_os;
    int n;
    bus(1'b1, `PCB_OFS_CTRL, 32'h0);
    bus(1'b1, `PCB_OFS_FUNC, 32'h0002_0005);
    bus(1'b1, `PCB_OFS_CTRL, 32'h1);
    mrst();
    sen.pulse(0, 1);
    idle(100);
    sen.pulse(1, 1);
    sen.pulse(0, 1);
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (n < 2000 && out2_o === 1'b1);
    @(posedge sys_clk_i);
    chk(32'(n >= 9 * CPM && n <= 11 * CPM), 32'h1);
  endtask : s_os

  // Count from one to below zero; key clears, then the reset input does
  task automatic s_err;
    sen.pulse(1, 2);
    idle(8);
    chk(32'(error_o), 32'h1);
    chk(32'(out1_o), 32'h1);
    rdc(`PCB_OFS_PV, 32'h0);
    bus(1'b1, `PCB_OFS_CTRL, 32'h3);
    chk(32'(error_o), 32'h0);
    sen.pulse(1, 1);
    chk(32'(error_o), 32'h1);
    mrst();
    chk(32'(error_o), 32'h0);
  endtask : s_err

  // Power cycle with kept batch level, strap moved while powered
  task automatic s_pwr;
    pwr(1'b1, 1'b1);
    chk(32'(batch_out_o), 32'h1);
    strap_two_stage_i <= 1'b0;
    idle(4);
    bus(1'b0, `PCB_OFS_STAT, 32'h0);
    chk(32'(v[7]), 32'h1);
    mrst();
    chk(32'(out2_o), 32'h0);
    pwr(1'b0, 1'b0);
  endtask : s_pwr

  // Plus/minus straps: compensation ignored after a down count, acts after an up count
  task automatic s_pm;
    strap_pm_range_i <= 1'b1;
    pwr(1'b0, 1'b0);
    bus(1'b1, `PCB_OFS_COMP, 32'h7);
    bus(1'b1, `PCB_OFS_CTRL, 32'h0);
    bus(1'b1, `PCB_OFS_CTRL, 32'h1);
    sen.pulse(1, 2);
    sen.pulse(4, 1);
    rdc(`PCB_OFS_PV, 32'h00ff_fffe);
    sen.pulse(0, 1);
    sen.pulse(4, 1);
    rdc(`PCB_OFS_PV, 32'h7);
  endtask : s_pm

  // Reset for 8 cycles, then the scenarios in turn
  initial begin
    nrst_i = 1'b0;
    strap_two_stage_i = 1'b0;
    strap_pm_range_i = 1'b0;
    kept_batch_out_i = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    n_mismatch = 0;
    compares = 0;
    idle(8);
    nrst_i <= 1'b1;
    idle(2);
    rdc(`PCB_OFS_FUNC, `PCB_FUNC_RST);
    bus(1'b0, 8'h24, 32'h0);
    chk(r, 32'h2);
    bus(1'b1, `PCB_OFS_PV, 32'h5);
    chk(r, 32'h2);
    s_count();
    s_batch();
    s_os();
    s_err();
    s_pwr();
    s_pm();
    summarize();
  end
endmodule : pcb_top_tb
`default_nettype wire
